// File: inc/scf_pkg.sv
// Purpose: shared constants and types of the serial command front end
// Assumes: one 200 MHz clock, asynchronous active-high reset
// Notes: keyword table holds long forms; short forms are derived
package scf_pkg;
  localparam int CLK_HZ = 200_000_000; // system clock rate
  localparam int BAUD_NUM = 5;
  localparam int BAUD_TABLE [BAUD_NUM] = '{1200, 9600, 38400, 57600, 115200};
  localparam int BAUD_DEF = 1; // out-of-range select falls back here
  localparam int CNT_W = 18; // holds the slowest bit period
  localparam logic [2:0] LAST_DATA_BIT = 3'h7; // eight data bits
  localparam logic [3:0] FRAME_LAST = 4'h9; // start, 8 data, stop
  localparam int KW_MAX = 12; // longest keyword buffered
  localparam int SHORT_MAX = 4; // long forms up to this are short too
  localparam int VOWEL_POS = 3; // index of the fourth character
  localparam int NODE_W = 4;
  localparam int NODES = 16;
  localparam logic [NODE_W-1:0] ROOT = 4'h0;
  localparam logic [NODE_W-1:0] NO_PARENT = 4'hF;
  // characters with a meaning to the parser
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_STAR = 8'h2A;
  localparam logic [7:0] CH_COLON = 8'h3A;
  localparam logic [7:0] CH_SEMI = 8'h3B;
  localparam logic [7:0] CH_QUERY = 8'h3F;
  localparam logic [7:0] CASE_BIT = 8'h20;

  typedef logic [8*KW_MAX-1:0] scf_text_t;
  typedef struct packed {
    scf_text_t text; // long form, last char in low byte
    logic [3:0] len;
    logic [NODE_W-1:0] parent;
  } scf_kw_t;
  // tree: subsystems at root, common commands start with a star
  localparam scf_kw_t KW_TABLE [NODES] = '{
    '{"", 4'h0, NO_PARENT}, '{"DISPLAY", 4'h7, ROOT},
    '{"FUNCTION", 4'h8, ROOT}, '{"FREQUENCY", 4'h9, ROOT},
    '{"COMPARATOR", 4'hA, ROOT}, '{"TRIGGER", 4'h7, ROOT},
    '{"LINE", 4'h4, 4'h1}, '{"PAGE", 4'h4, 4'h1},
    '{"IMPEDANCE", 4'h9, 4'h2}, '{"AUTO", 4'h4, 4'h8},
    '{"RANGE", 4'h5, 4'h8}, '{"PTOLERANCE", 4'hA, 4'h4},
    '{"*TRG", 4'h4, ROOT}, '{"*IDN", 4'h4, ROOT},
    '{"*SAV", 4'h4, ROOT}, '{"*RCL", 4'h4, ROOT}};

  typedef enum logic [1:0] {TK_CMD, TK_PARAM, TK_EOM, TK_ERR} scf_kind_t;
  typedef struct packed {
    scf_kind_t kind;
    logic [NODE_W-1:0] node; // matched keyword for commands
    logic query;
    logic [7:0] data; // terminator or parameter byte
  } scf_tok_t;

  function automatic logic [7:0] scf_upper(input logic [7:0] c);
    return (c >= "a" && c <= "z") ? (c & ~CASE_BIT) : c;
  endfunction : scf_upper

  function automatic logic scf_kw_char(input logic [7:0] c);
    return (c >= "A" && c <= "Z") || (c >= "0" && c <= "9") ||
           (c == CH_STAR);
  endfunction : scf_kw_char

  function automatic logic [7:0] scf_char(input scf_kw_t e, input int j);
    return e.text[8*(int'(e.len)-1-j) +: 8];
  endfunction : scf_char

  // short form length from the long form
  function automatic logic [3:0] scf_short_len(input scf_kw_t e);
    logic [7:0] c;
    c = scf_char(e, VOWEL_POS);
    if (int'(e.len) <= SHORT_MAX) return e.len;
    if (c == "A" || c == "E" || c == "I" || c == "O" || c == "U")
      return 4'(VOWEL_POS);
    return 4'(SHORT_MAX);
  endfunction : scf_short_len

  function automatic logic [CNT_W-1:0] scf_divisor(input int hz,
                                                    input logic [2:0] s);
    int b;
    b = (int'(s) < BAUD_NUM) ? BAUD_TABLE[s] : BAUD_TABLE[BAUD_DEF];
    return CNT_W'(hz / b);
  endfunction : scf_divisor
endpackage : scf_pkg

// File: rtl/scf_front_end.sv
// Purpose: serial receiver, transmitter and command tree parser
// Assumes: baud_sel and core-side ports are on mclk
// Notes: tokens leave through a two-entry buffer; a full buffer
// Notes: stalls the parser, and only then can a byte overrun
module scf_front_end
  import scf_pkg::*;
#(
  parameter int CLK_HZ_P = CLK_HZ // source of all bit periods
) (
  // clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // line setting
  input wire logic [2:0] baud_sel,
  // serial pins, data lines only
  input wire logic rxd,
  output logic txd,
  // reply bytes from the instrument core
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  // parsed tokens toward the core
  output scf_tok_t tok,
  output logic tok_valid,
  input wire logic tok_ready,
  // line status pulses
  output logic rx_overrun,
  output logic frame_err
);
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} scf_rx_t;
  typedef enum logic {TX_IDLE, TX_SEND} scf_tx_t;
  typedef enum logic [1:0] {P_KW, P_PARAM, P_SKIP} scf_ps_t;

  logic [CNT_W-1:0] div; // cycles per bit at the chosen rate

  // both ends share one rate, no flow-control pins exist
  always_comb begin
    div = scf_divisor(CLK_HZ_P, baud_sel);
  end

  // receiver state
  logic rx_s1, rx_s2; // pin synchroniser
  scf_rx_t rx_st, next_rx_st;
  logic [CNT_W-1:0] rx_cnt, next_rx_cnt;
  logic [2:0] rx_bit, next_rx_bit;
  logic [7:0] rx_sh, next_rx_sh;
  logic [7:0] hold, next_hold; // one received byte
  logic hold_v, next_hold_v;
  logic next_overrun, next_frame_err;
  logic consume; // parser takes the held byte

  // receiver: sample mid-bit, start bit rechecked to reject glitches
  always_comb begin
    next_rx_st = rx_st;
    next_rx_cnt = rx_cnt;
    next_rx_bit = rx_bit;
    next_rx_sh = rx_sh;
    next_hold = hold;
    next_hold_v = hold_v & ~consume;
    next_overrun = 1'b0;
    next_frame_err = 1'b0;
    unique case (rx_st)
      RX_IDLE: begin
        if (!rx_s2) begin
          next_rx_st = RX_START;
          next_rx_cnt = div >> 1;
        end
      end
      RX_START: begin
        if (rx_cnt != '0) begin
          next_rx_cnt = rx_cnt - 1'b1;
        end else if (rx_s2) begin
          next_rx_st = RX_IDLE; // too short to be a start bit
        end else begin
          next_rx_st = RX_DATA;
          next_rx_cnt = div - 1'b1;
          next_rx_bit = '0;
        end
      end
      RX_DATA: begin
        if (rx_cnt != '0) begin
          next_rx_cnt = rx_cnt - 1'b1;
        end else begin
          next_rx_sh = {rx_s2, rx_sh[7:1]}; // lsb first
          next_rx_cnt = div - 1'b1;
          next_rx_bit = rx_bit + 1'b1;
          if (rx_bit == LAST_DATA_BIT) next_rx_st = RX_STOP;
        end
      end
      RX_STOP: begin
        if (rx_cnt != '0) begin
          next_rx_cnt = rx_cnt - 1'b1;
        end else begin
          next_rx_st = RX_IDLE;
          if (!rx_s2) begin
            next_frame_err = 1'b1; // no stop bit, byte dropped
          end else if (next_hold_v) begin
            next_overrun = 1'b1; // parser still stalled
          end else begin
            next_hold = rx_sh;
            next_hold_v = 1'b1;
          end
        end
      end
    endcase
  end

  // receiver registers
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_st <= RX_IDLE;
      rx_cnt <= '0;
      rx_bit <= '0;
      rx_sh <= '0;
      hold <= '0;
      hold_v <= 1'b0;
      rx_overrun <= 1'b0;
      frame_err <= 1'b0;
    end else begin
      rx_s1 <= rxd;
      rx_s2 <= rx_s1;
      rx_st <= next_rx_st;
      rx_cnt <= next_rx_cnt;
      rx_bit <= next_rx_bit;
      rx_sh <= next_rx_sh;
      hold <= next_hold;
      hold_v <= next_hold_v;
      rx_overrun <= next_overrun;
      frame_err <= next_frame_err;
    end
  end

  // transmitter state
  scf_tx_t tx_st, next_tx_st;
  logic [CNT_W-1:0] tx_cnt, next_tx_cnt;
  logic [3:0] tx_bit, next_tx_bit;
  logic [9:0] tx_sh, next_tx_sh; // stop, data, start
  logic next_txd, next_tx_ready;

  // transmitter: one frame per accepted byte, line idles high
  always_comb begin
    next_tx_st = tx_st;
    next_tx_cnt = tx_cnt;
    next_tx_bit = tx_bit;
    next_tx_sh = tx_sh;
    next_txd = txd;
    next_tx_ready = tx_ready;
    unique case (tx_st)
      TX_IDLE: begin
        if (tx_valid && tx_ready) begin
          next_tx_sh = {1'b1, tx_data, 1'b0};
          next_txd = 1'b0;
          next_tx_cnt = div - 1'b1;
          next_tx_bit = '0;
          next_tx_ready = 1'b0;
          next_tx_st = TX_SEND;
        end
      end
      TX_SEND: begin
        if (tx_cnt != '0) begin
          next_tx_cnt = tx_cnt - 1'b1;
        end else if (tx_bit == FRAME_LAST) begin
          next_tx_st = TX_IDLE; // stop bit served
          next_tx_ready = 1'b1;
        end else begin
          next_tx_sh = tx_sh >> 1;
          next_txd = tx_sh[1];
          next_tx_bit = tx_bit + 1'b1;
          next_tx_cnt = div - 1'b1;
        end
      end
    endcase
  end

  // transmitter registers
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_st <= TX_IDLE;
      tx_cnt <= '0;
      tx_bit <= '0;
      tx_sh <= '0;
      txd <= 1'b1;
      tx_ready <= 1'b1;
    end else begin
      tx_st <= next_tx_st;
      tx_cnt <= next_tx_cnt;
      tx_bit <= next_tx_bit;
      tx_sh <= next_tx_sh;
      txd <= next_txd;
      tx_ready <= next_tx_ready;
    end
  end

  // parser and token buffer state
  scf_ps_t p_st, next_p_st;
  logic [NODE_W-1:0] node, next_node; // current tree path
  scf_text_t buf_q, next_buf; // keyword, first char in low byte
  logic [3:0] len, next_len;
  logic query, next_query;
  scf_tok_t tail, next_tail, next_tok, push_tok;
  logic tail_v, next_tail_v, next_tok_valid, push;
  logic hit; // keyword found under current node
  logic [NODE_W-1:0] hit_id;
  logic [7:0] c_up;

  // lookup: a child of node whose long or short form equals the buffer
  always_comb begin
    logic eq;
    hit = 1'b0;
    hit_id = ROOT;
    eq = 1'b0;
    for (int i = 1; i < NODES; i++) begin
      eq = (KW_TABLE[i].parent == node) && (len != '0) &&
           (len == KW_TABLE[i].len ||
            len == scf_short_len(KW_TABLE[i]));
      for (int j = 0; j < KW_MAX; j++) begin
        if (j < int'(len) && buf_q[8*j +: 8] != scf_char(KW_TABLE[i], j))
          eq = 1'b0;
      end
      if (eq && !hit) begin
        hit = 1'b1;
        hit_id = NODE_W'(i);
      end
    end
  end

  // parser: splits a message into command, parameter and end tokens
  always_comb begin
    c_up = scf_upper(hold);
    consume = hold_v & ~tail_v; // stall while the buffer is full
    next_p_st = p_st;
    next_node = node;
    next_buf = buf_q;
    next_len = len;
    next_query = query;
    push = 1'b0;
    push_tok = '{kind: TK_ERR, node: node, query: query, data: hold};
    if (consume) begin
      unique case (p_st)
        P_KW: begin
          if (c_up == CH_COLON) begin
            if (len == '0) begin
              next_node = ROOT; // leading colon restarts at the top
            end else if (hit && !query) begin
              next_node = hit_id;
              next_len = '0;
            end else begin
              push = 1'b1;
              next_p_st = P_SKIP;
            end
          end else if (c_up == CH_SPACE || c_up == CH_SEMI ||
                       c_up == CH_LF) begin
            next_len = '0;
            next_query = 1'b0;
            if (len != '0) begin
              push = 1'b1;
              push_tok.kind = hit ? TK_CMD : TK_ERR;
              push_tok.node = hit_id;
              if (c_up == CH_SPACE) begin
                next_p_st = hit ? P_PARAM : P_SKIP;
              end
            end else if (c_up == CH_LF) begin
              push = 1'b1;
              push_tok.kind = TK_EOM;
            end
            if (c_up == CH_LF) next_node = ROOT;
          end else if (c_up == CH_QUERY && len != '0) begin
            next_query = 1'b1;
          end else if (scf_kw_char(c_up) && int'(len) < KW_MAX && !query) begin
            next_buf[8*len +: 8] = c_up;
            next_len = len + 1'b1;
          end else begin
            push = 1'b1;
            next_p_st = P_SKIP;
            next_len = '0;
            next_query = 1'b0;
          end
        end
        P_PARAM: begin
          if (c_up == CH_SEMI) begin
            next_p_st = P_KW;
          end else if (c_up == CH_LF) begin
            push = 1'b1;
            push_tok.kind = TK_EOM;
            next_node = ROOT;
            next_p_st = P_KW;
          end else begin
            push = 1'b1;
            push_tok.kind = TK_PARAM;
          end
        end
        default: begin
          next_len = '0;
          next_query = 1'b0;
          if (c_up == CH_SEMI) next_p_st = P_KW;
          if (c_up == CH_LF) begin
            push = 1'b1;
            push_tok.kind = TK_EOM;
            next_node = ROOT;
            next_p_st = P_KW;
          end
        end
      endcase
    end
    // two-entry buffer: head is the output, tail takes the overflow
    next_tok = tok;
    next_tok_valid = tok_valid;
    next_tail = tail;
    next_tail_v = tail_v;
    if (tok_valid && tok_ready) begin
      next_tok = tail;
      next_tok_valid = tail_v;
      next_tail_v = 1'b0;
    end
    if (push && !next_tok_valid) begin
      next_tok = push_tok;
      next_tok_valid = 1'b1;
    end else if (push) begin
      next_tail = push_tok;
      next_tail_v = 1'b1;
    end
  end

  // parser and buffer registers
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      p_st <= P_KW;
      node <= ROOT;
      buf_q <= '0;
      len <= '0;
      query <= 1'b0;
      tok <= '0;
      tok_valid <= 1'b0;
      tail <= '0;
      tail_v <= 1'b0;
    end else begin
      p_st <= next_p_st;
      node <= next_node;
      buf_q <= next_buf;
      len <= next_len;
      query <= next_query;
      tok <= next_tok;
      tok_valid <= next_tok_valid;
      tail <= next_tail;
      tail_v <= next_tail_v;
    end
  end

  // checks on the design's own behaviour
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_tx_start_low: assert property (tx_st == TX_IDLE && tx_valid &&
    tx_ready |=> !txd && tx_st == TX_SEND) else $error("no start bit");
  a_tx_stop_high: assert property (tx_st == TX_SEND &&
    tx_bit == FRAME_LAST |-> txd) else $error("stop bit not high");
  a_tx_bit_edge: assert property (!$stable(txd) |->
    $past(tx_cnt) == '0 || $past(tx_st) == TX_IDLE)
    else $error("line changed mid bit");
  a_rx_byte_keep: assert property (rx_st == RX_STOP && rx_cnt == '0 &&
    rx_s2 && !hold_v |=> hold_v && hold == $past(rx_sh))
    else $error("good frame lost");
  a_lf_path_reset: assert property (consume && c_up == CH_LF |=>
    node == ROOT && p_st == P_KW) else $error("line feed kept path");
  a_semi_path_keep: assert property (consume && c_up == CH_SEMI |=>
    node == $past(node)) else $error("semicolon moved path");
  a_colon_desc: assert property (consume && p_st == P_KW &&
    c_up == CH_COLON && len != '0 && hit && !query |=>
    node == $past(hit_id) && len == '0) else $error("colon no descend");
  a_bad_kw_skip: assert property (consume && p_st == P_KW &&
    c_up == CH_SPACE && len != '0 && !hit |=> p_st == P_SKIP ##0
    (tok_valid || tail_v)) else $error("bad keyword accepted");
  a_stall_hold: assert property (hold_v && tail_v |=> hold_v)
    else $error("byte lost on stall");

  c_cmd_token: cover property (push && push_tok.kind == TK_CMD);
  c_param_token: cover property (push && push_tok.kind == TK_PARAM);
  c_err_token: cover property (push && push_tok.kind == TK_ERR);
  c_buffer_full: cover property (tail_v && tok_valid && !tok_ready);
endmodule : scf_front_end

// File: verification/scf_host_model.sv
// Purpose: serial controller model at the far side of the front end
// Assumes: caller gives the bit period in mclk cycles
// Notes: drives rxd on falling edges; the line idles high between frames
module scf_host_model
  import scf_pkg::*;
(
  // clock
  input wire logic mclk,
  // serial lines, data only, no handshake lines at all
  output logic rxd,
  input wire logic txd
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle level of an unframed line
  initial rxd = 1'b1;

  // one frame: start, eight data lsb first, one stop (stop may be forced)
  task automatic send(input logic [7:0] b, input int div,
                      input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge mclk);
      rxd = f[i];
      repeat (div - 1) @(negedge mclk);
    end
    @(negedge mclk);
    rxd = 1'b1;
  endtask : send

  // catch one frame on txd, sampling each bit in its middle
  task automatic recv(input int div, output logic [7:0] b,
                      output logic stop, output logic ok);
    ok = 1'b0;
    b = 8'h00;
    for (int n = 0; n < 40 && !ok; n++) begin
      @(negedge mclk);
      ok = (txd === 1'b0);
    end
    repeat (div / 2) @(negedge mclk);
    for (int i = 0; i < 8; i++) begin
      repeat (div) @(negedge mclk);
      b[i] = txd;
    end
    repeat (div) @(negedge mclk);
    stop = txd;
  endtask : recv
endmodule : scf_host_model

// File: verification/scf_front_end_bench.sv
// Purpose: self-checking bench of the serial command front end
// Assumes: shortened clock rate so that baud_sel 4 gives ten cycles a bit
// Notes: inputs change on falling edges; tokens are queued on rising ones
module scf_front_end_bench
  import scf_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SIM_HZ = 1_152_000; // short bit periods, short run
  localparam int DIV = SIM_HZ / BAUD_TABLE[4]; // cycles a bit at 115200
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] baud_sel = 3'h4;
  wire rxd; // driven by the controller model
  logic txd;
  logic [7:0] tx_data = 8'h00;
  logic tx_valid = 1'b0;
  logic tx_ready;
  scf_tok_t tok;
  logic tok_valid;
  logic tok_ready = 1'b1;
  logic rx_overrun;
  logic frame_err;
  int errors = 0;
  int comparisons = 0;
  int n_ferr = 0; // frame error pulses seen
  int n_ovr = 0; // overrun pulses seen
  scf_tok_t got_q[$]; // tokens taken, in order

  always #2.5 mclk = ~mclk;

  scf_front_end #(.CLK_HZ_P(SIM_HZ)) i_scf_front_end (
    .mclk(mclk), .sys_rst(sys_rst), .baud_sel(baud_sel), .rxd(rxd),
    .txd(txd), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tok(tok), .tok_valid(tok_valid),
    .tok_ready(tok_ready), .rx_overrun(rx_overrun),
    .frame_err(frame_err));
  scf_host_model i_scf_host_model (.mclk(mclk), .rxd(rxd), .txd(txd));

  // take tokens at the handshake edge; pulses stand one cycle only
  always @(posedge mclk) begin
    if (tok_valid === 1'b1 && tok_ready === 1'b1) got_q.push_back(tok);
    if (frame_err === 1'b1) n_ferr++;
    if (rx_overrun === 1'b1) n_ovr++;
  end

  task automatic summarize();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string what, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  // a bound that ran out ends the run
  task automatic fail_out(input string what);
    errors++;
    $display("wrong value %s expected arrival seen none", what);
    summarize();
  endtask : fail_out

  // send a whole message at the default rate
  task automatic say(input string s);
    for (int i = 0; i < s.len(); i++) begin
      i_scf_host_model.send(s[i], DIV, 1'b1);
    end
  endtask : say

  // next token; node and query only matter for commands
  task automatic want(input scf_kind_t k, input logic [3:0] n,
                      input logic q, input logic [7:0] d);
    scf_tok_t e;
    scf_tok_t g;
    e = '{kind: k, node: n, query: q, data: d};
    for (int i = 0; i < 4 * DIV && got_q.size() == 0; i++) begin
      @(negedge mclk);
    end
    if (got_q.size() == 0) fail_out("token");
    g = got_q.pop_front();
    if (k != TK_CMD) begin
      g.node = 4'h0;
      g.query = 1'b0;
    end
    if (k == TK_ERR) g.data = 8'h00; // error carries whichever byte ended the keyword; not compared
    chk("token", 32'(e), 32'(g));
  endtask : want

  // transmit one byte at every in-range rate select and at out-of-range select 5
  task automatic t_tx();
    logic [7:0] b;
    logic [7:0] v;
    logic stop;
    logic ok;
    int div;
    int low;
    for (int s = 0; s < 6; s++) begin
      div = SIM_HZ / BAUD_TABLE[(s < BAUD_NUM) ? s : BAUD_DEF];
      v = 8'hC4 + 8'(s);
      @(negedge mclk);
      baud_sel = 3'(s);
      @(negedge mclk);
      tx_data = v;
      tx_valid = 1'b1;
      fork
        i_scf_host_model.recv(div, b, stop, ok);
        begin
          @(negedge mclk);
          tx_valid = 1'b0;
          low = 0;
          while (tx_ready === 1'b0 && low < 11 * div) begin
            low++;
            @(negedge mclk);
          end
        end
      join
      chk("tx start bit", 32'h1, 32'(ok));
      chk("tx byte", 32'(v), 32'(b));
      chk("tx stop bit", 32'h1, 32'(stop));
      chk("tx frame cycles", 32'(10 * div), 32'(low));
    end
    @(negedge mclk);
    baud_sel = 3'h4;
  endtask : t_tx

  // colon descent, parameters after a space, line feed ends it
  task automatic t_tree();
    string p;
    p = "SYST";
    say("DISP:PAGE SYST\n");
    want(TK_CMD, 4'h7, 1'b0, CH_SPACE);
    for (int i = 0; i < 4; i++) want(TK_PARAM, 4'h0, 1'b0, p[i]);
    want(TK_EOM, 4'h0, 1'b0, CH_LF);
  endtask : t_tree

  // short forms in lower case; semicolon keeps the path
  task automatic t_short();
    say("func:imp:auto;rang?\n");
    want(TK_CMD, 4'h9, 1'b0, CH_SEMI);
    want(TK_CMD, 4'hA, 1'b1, CH_LF);
    say("COMP:PTOL\n");
    want(TK_CMD, 4'hB, 1'b0, CH_LF);
    say("DISPLAY:LINE\n");
    want(TK_CMD, 4'h6, 1'b0, CH_LF);
    say("FrEqUeNcY\n");
    want(TK_CMD, 4'h3, 1'b0, CH_LF);
  endtask : t_short

  // child at root is refused; bad keyword skipped to the separator
  task automatic t_level();
    say("PAGE\n");
    want(TK_ERR, 4'h0, 1'b0, 8'h00);
    // the refused header already closed the message: no end token
    say(":DISP:PAGE?\n");
    want(TK_CMD, 4'h7, 1'b1, CH_LF);
    say("DISP:XYZ 5;PAGE\n");
    want(TK_ERR, 4'h0, 1'b0, 8'h00);
    want(TK_CMD, 4'h7, 1'b0, CH_LF);
    say("*IDN?\n");
    want(TK_CMD, 4'hD, 1'b1, CH_LF);
  endtask : t_level

  // low stop bit drops the byte and the parser carries on
  task automatic t_ferr();
    int f0;
    f0 = n_ferr;
    i_scf_host_model.send(CH_STAR, DIV, 1'b0);
    repeat (DIV) @(negedge mclk);
    chk("frame errors", 32'h1, 32'(n_ferr - f0));
    say("*TRG\n");
    want(TK_CMD, 4'hC, 1'b0, CH_LF);
  endtask : t_ferr

  // consumer stalls: two tokens wait, the next byte stays held, the rest
  // overrun; only the held star survives, so the line feed rejects it
  task automatic t_stall();
    int o0;
    o0 = n_ovr;
    @(negedge mclk);
    tok_ready = 1'b0;
    say("*TRG;*SAV;*RCL;*IDN\n");
    chk("token waiting", 32'h1, 32'(tok_valid));
    chk("overrun seen", 32'h1, 32'(n_ovr > o0));
    @(negedge mclk);
    tok_ready = 1'b1;
    want(TK_CMD, 4'hC, 1'b0, CH_SEMI);
    want(TK_CMD, 4'hE, 1'b0, CH_SEMI);
    say("\n");
    want(TK_ERR, 4'h0, 1'b0, 8'h00);
  endtask : t_stall

  initial begin
    repeat (2) @(posedge mclk);
    chk("reset txd", 32'h1, 32'(txd));
    chk("reset tx_ready", 32'h1, 32'(tx_ready));
    chk("reset tok_valid", 32'h0, 32'(tok_valid));
    @(negedge mclk);
    sys_rst = 1'b0;
    t_tx();
    t_tree();
    t_short();
    t_level();
    t_ferr();
    t_stall();
    chk("spare tokens", 32'h0, 32'(got_q.size()));
    summarize();
  end
endmodule : scf_front_end_bench
